// ### dv/far_end_model.sv
// remote multiplexer across the link: status pins and link loopback on request
// assumes same clock as the local device, one link bit every four cycles
`timescale 1ns/1ps
module far_end_model (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic reset_in,
    // from local device
    input  wire logic tx_bit_in,
    input  wire logic loop_request_in,
    // scenario controls
    input  wire logic rts_loss_in,
    input  wire logic frame_loss_in,
    input  wire logic sensor_in,
    input  wire logic inject_in,
    // toward local device
    output logic      strobe_out,
    output logic      rx_bit_out,
    output logic      rts_loss_out,
    output logic      frame_loss_out,
    output logic      sensor_out
);
    logic [1:0] div;
    always_ff @(posedge clk_in) begin
        div <= reset_in ? 2'h0 : div + 2'h1;
        strobe_out <= !reset_in && div == 2'h3;
        rts_loss_out <= rts_loss_in;
        frame_loss_out <= frame_loss_in;
        sensor_out <= sensor_in;
        // idle line sends all ones
        if (reset_in || !loop_request_in) begin
            rx_bit_out <= 1'b1;
        end else if (strobe_out) begin
            rx_bit_out <= tx_bit_in ^ inject_in;
        end
    end
endmodule

// ### dv/mux_alarm_loop_bit_error_tester_status_test.sv
// self-checking bench for the supervisor with a far end model
// assumes 100 MHz clock, short flash divider for simulation
`timescale 1ns/1ps
module mux_alarm_loop_bit_error_tester_status_test
    import supervisor_pkg::*;
;
    logic clk_in = 0, reset_in = 1, link_rts_in = 1, link_frame_loss_in = 0, link_high_error_in = 0;
    logic far_rts = 0, far_frame = 0, far_sens = 0, inject = 0, far_end_loop_request_in = 0, tx_mux_bit_in = 0;
    logic rx_trib_data_valid_in = 1, link_loop_enable_in = 1, remote_loop_enable_in = 0, tester_enable_in = 0;
    logic tester_prbs_select_in = 1, sensor_alarm_on_open_in = 0, sensor_closed_in = 0;
    logic [3:0] port_carrier_loss_in = 0, port_ais_rx_in = 0, port_code_error_in = 0, port_in_use_in = 4'hf;
    logic [3:0] port_loop_enable_in = 0, trib_loop_enable_in = 0;
    logic link_bit_strobe_in, link_rx_bit_in, far_end_rts_loss_in, far_end_frame_loss_in, far_end_sensor_alarm_in;
    logic link_signal_loss_led_out, link_error_led_out, far_end_error_led_out, test_mode_led_out, power_led_out;
    logic alarm_relay_out, sensor_alarm_tx_out, remote_loop_request_out, link_loop_active_out, link_tx_bit_out;
    logic pattern_not_detected_out;
    logic [3:0] tributary_loss_led_out, port_state_led_out, port_ais_out, port_loop_active_out, trib_loop_active_out;
    logic [ERR_CNT_W-1:0] bit_error_count_out;
    int mismatches = 0, check_count = 0, n;
    mux_alarm_loop_bit_error_tester_status #(.PORTS(4), .TICK_DIV(4)) uut (.*);
    far_end_model far (.clk_in(clk_in), .reset_in(reset_in), .tx_bit_in(link_tx_bit_out),
        .loop_request_in(remote_loop_request_out), .rts_loss_in(far_rts), .frame_loss_in(far_frame),
        .sensor_in(far_sens), .inject_in(inject), .strobe_out(link_bit_strobe_in), .rx_bit_out(link_rx_bit_in),
        .rts_loss_out(far_end_rts_loss_in), .frame_loss_out(far_end_frame_loss_in), .sensor_out(far_end_sensor_alarm_in));
    always #5 clk_in = ~clk_in;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(negedge clk_in);
    endtask
    task automatic count32(input int sel, output int cnt);
        logic b;
        cnt = 0;
        tick(40);
        repeat (32) begin
            tick(1);
            b = sel < 4 ? port_state_led_out[sel] : sel == 4 ? test_mode_led_out : sel == 5 ? link_error_led_out
                : tributary_loss_led_out[2];
            cnt += (b === 1'b1);
        end
    endtask
    task automatic wait_lock();
        for (int i = 0; i < 12000 && pattern_not_detected_out !== 1'b0; i++) tick(1);
        check(pattern_not_detected_out, 1'b0);
    endtask
    task automatic s_reset();
        tick(6);
        check({alarm_relay_out, link_loop_active_out, port_ais_out}, {RELAY_ALARM, 1'b0, 4'hf});
        link_loop_enable_in = 0;
        reset_in = 0;
        tick(8);
        check({power_led_out, alarm_relay_out, port_ais_out}, {1'b1, RELAY_NORMAL, 4'h0});
    endtask
    task automatic s_link();
        far_rts = 1;
        link_rts_in = 0;
        tick(8);
        check({link_signal_loss_led_out, alarm_relay_out, port_ais_out, far_end_error_led_out}, 7'h5e);
        link_rts_in = 1;
        tick(8);
        check({link_signal_loss_led_out, far_end_error_led_out, alarm_relay_out}, 3'h3);
        far_rts = 0;
        far_frame = 1;
        link_frame_loss_in = 1;
        tick(8);
        check({far_end_error_led_out, alarm_relay_out}, 2'h2);
        far_frame = 0;
        link_frame_loss_in = 0;
        link_high_error_in = 1;
        count32(5, n);
        check({n != 0, alarm_relay_out, port_ais_out}, 6'h2f);
        link_high_error_in = 0;
    endtask
    task automatic s_ports();
        port_in_use_in = 4'h7;
        port_carrier_loss_in = 4'h8;
        tick(8);
        check({alarm_relay_out, port_state_led_out}, 5'h17);
        port_carrier_loss_in = 4'h1;
        tick(8);
        check({alarm_relay_out, tributary_loss_led_out[0]}, 2'h1);
        port_carrier_loss_in = 0;
        port_ais_rx_in = 4'h2;
        tick(8);
        check(tributary_loss_led_out, 4'h2);
        port_ais_rx_in = 0;
        port_code_error_in = 4'h4;
        count32(6, n);
        check(n > 0 && n < 32, 1'b1);
        port_code_error_in = 0;
        port_in_use_in = 4'hf;
    endtask
    task automatic s_sensor();
        sensor_closed_in = 1;
        tick(3);
        check(sensor_alarm_tx_out, 1'b1);
        sensor_alarm_on_open_in = 1;
        tick(3);
        check(sensor_alarm_tx_out, 1'b0);
        sensor_closed_in = 0;
        far_sens = 1;
        tick(8);
        check({sensor_alarm_tx_out, alarm_relay_out}, 2'h2);
        far_sens = 0;
    endtask
    task automatic s_loops();
        port_loop_enable_in = 4'h1;
        trib_loop_enable_in = 4'h2;
        count32(0, n);
        check(n, 16);
        count32(1, n);
        check({n[7:0], port_ais_out, port_loop_active_out, trib_loop_active_out}, 20'h08212);
        port_loop_enable_in = 0;
        trib_loop_enable_in = 0;
        link_loop_enable_in = 1;
        count32(4, n);
        check({n[7:0], link_loop_active_out, port_ais_out, link_tx_bit_out}, 14'h43f);
        link_loop_enable_in = 0;
        far_end_loop_request_in = 1;
        tick(3);
        check(link_loop_active_out, 1'b1);
        far_end_loop_request_in = 0;
        remote_loop_enable_in = 1;
        count32(4, n);
        check({n[7:0], remote_loop_request_out, link_tx_bit_out}, 10'h22);
    endtask
    task automatic s_tester();
        remote_loop_enable_in = 0;
        rx_trib_data_valid_in = 0;
        tick(3);
        check(port_ais_out, 4'hf);
        rx_trib_data_valid_in = 1;
        tester_enable_in = 1;
        tick(200);
        check({pattern_not_detected_out, port_ais_out}, 5'h1f);
        remote_loop_enable_in = 1;
        wait_lock();
        check(bit_error_count_out, 0);
        tick(2);
        check(link_error_led_out, 1'b1);
        inject = 1;
        count32(5, n);
        inject = 0;
        check({n != 0, bit_error_count_out != 0}, 2'h3);
        tester_enable_in = 0;
        tick(3);
        check(bit_error_count_out, 0);
        tester_prbs_select_in = 0;
        tester_enable_in = 1;
        wait_lock();
        check(bit_error_count_out, 0);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #400000;
        mismatches++;
        end_sim();
    end
    initial begin
        s_reset();
        s_link();
        s_ports();
        s_sensor();
        s_loops();
        s_tester();
        end_sim();
    end
endmodule

// ### dv/supervisor_asserts.sv
// port assertions for the supervisor
// assumes bind into mux_alarm_loop_bit_error_tester_status, single clock domain
`timescale 1ns/1ps
module supervisor_asserts
    import supervisor_pkg::*;
#(
    parameter int PORTS = 4
) (
    // clock and reset
    input wire logic                 clk_in,
    input wire logic                 reset_in,
    // watched inputs
    input wire logic                 link_rts_in,
    input wire logic                 link_frame_loss_in,
    input wire logic                 far_end_sensor_alarm_in,
    input wire logic                 link_loop_enable_in,
    input wire logic                 remote_loop_enable_in,
    input wire logic                 tester_enable_in,
    input wire logic                 sensor_alarm_on_open_in,
    input wire logic                 sensor_closed_in,
    input wire logic [PORTS-1:0]     port_in_use_in,
    input wire logic [PORTS-1:0]     port_carrier_loss_in,
    input wire logic [PORTS-1:0]     trib_loop_enable_in,
    // watched outputs
    input wire logic                 link_signal_loss_led_out,
    input wire logic                 far_end_error_led_out,
    input wire logic                 alarm_relay_out,
    input wire logic                 sensor_alarm_tx_out,
    input wire logic                 remote_loop_request_out,
    input wire logic                 link_loop_active_out,
    input wire logic [PORTS-1:0]     port_ais_out,
    input wire logic [PORTS-1:0]     trib_loop_active_out,
    input wire logic [ERR_CNT_W-1:0] bit_error_count_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    AST_LOSS_LED: assert property (!link_rts_in [*7] |-> link_signal_loss_led_out)
        else $error("loss led not lit");
    AST_LOSS_RELAY: assert property (!link_rts_in [*7] |-> alarm_relay_out == RELAY_ALARM && &port_ais_out)
        else $error("link loss without relay or ais");
    AST_FAR_GATED: assert property (!link_rts_in [*7] |-> !far_end_error_led_out)
        else $error("far end led lit without local rts");
    AST_FRAME_RELAY: assert property (link_frame_loss_in [*7] |-> alarm_relay_out == RELAY_ALARM)
        else $error("frame loss without relay");
    AST_PORT_RELAY: assert property ((port_in_use_in[0] && port_carrier_loss_in[0]) [*7] |-> !alarm_relay_out)
        else $error("in-use port loss without relay");
    AST_SENSOR_RELAY: assert property (far_end_sensor_alarm_in [*7] |-> alarm_relay_out == RELAY_ALARM)
        else $error("remote sensor without relay");
    AST_SENSOR_TX: assert property ((sensor_closed_in ^ sensor_alarm_on_open_in) [*3] |-> sensor_alarm_tx_out)
        else $error("sensor alarm not sent");
    AST_LOOP_AIS: assert property (link_loop_enable_in [*4] |-> link_loop_active_out && &port_ais_out)
        else $error("link loop without ais");
    AST_TESTER_AIS: assert property (tester_enable_in [*4] |-> port_ais_out == '1)
        else $error("tester on without ais");
    AST_TRIB_AIS: assert property (trib_loop_enable_in[1] [*4] |-> port_ais_out[1] && trib_loop_active_out[1])
        else $error("trib loop without ais");
    AST_REMOTE_REQ: assert property (remote_loop_enable_in [*3] |-> remote_loop_request_out)
        else $error("remote loop request missing");
    AST_COUNT_CLEAR: assert property (!tester_enable_in [*3] |-> bit_error_count_out == '0)
        else $error("error count not cleared");
    AST_RESET_STATE: assert property (disable iff (1'b0) reset_in |=> !link_loop_active_out && !alarm_relay_out)
        else $error("reset leaves loop or relay energised");
endmodule
bind mux_alarm_loop_bit_error_tester_status supervisor_asserts #(.PORTS(PORTS)) chk (.*);

// ### verilog/mux_alarm_loop_bit_error_tester_status.sv
// indicator, alarm relay, ais, loop and bit error tester supervision for a four-port e1 mux
// assumes status pins other than far_end_loop_request_in are asynchronous; link bit strobes and datapath flags come from clk_in logic
`timescale 1ns/1ps
module mux_alarm_loop_bit_error_tester_status
    import supervisor_pkg::*;
#(
    parameter int          PORTS         = 4,
    parameter int          TICK_DIV      = TICK_CYCLES,
    parameter logic [22:0] FIXED_PATTERN = 23'h2aaaaa
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             reset_in,
    // link port status pins
    input  wire logic             link_rts_in,
    input  wire logic             link_frame_loss_in,
    input  wire logic             link_high_error_in,
    input  wire logic             far_end_rts_loss_in,
    input  wire logic             far_end_frame_loss_in,
    input  wire logic             far_end_sensor_alarm_in,
    input  wire logic             far_end_loop_request_in,
    // link bit stream, same clock
    input  wire logic             link_bit_strobe_in,
    input  wire logic             link_rx_bit_in,
    input  wire logic             tx_mux_bit_in,
    input  wire logic             rx_trib_data_valid_in,
    // e1 port status pins
    input  wire logic [PORTS-1:0] port_carrier_loss_in,
    input  wire logic [PORTS-1:0] port_ais_rx_in,
    input  wire logic [PORTS-1:0] port_code_error_in,
    // configuration
    input  wire logic [PORTS-1:0] port_in_use_in,
    input  wire logic [PORTS-1:0] port_loop_enable_in,
    input  wire logic [PORTS-1:0] trib_loop_enable_in,
    input  wire logic             link_loop_enable_in,
    input  wire logic             remote_loop_enable_in,
    input  wire logic             tester_enable_in,
    input  wire logic             tester_prbs_select_in,
    input  wire logic             sensor_alarm_on_open_in,
    input  wire logic             sensor_closed_in,
    // indicators and relay
    output logic                  link_signal_loss_led_out,
    output logic                  link_error_led_out,
    output logic                  far_end_error_led_out,
    output logic                  test_mode_led_out,
    output logic                  power_led_out,
    output logic [PORTS-1:0]      tributary_loss_led_out,
    output logic [PORTS-1:0]      port_state_led_out,
    output logic                  alarm_relay_out,
    // link and e1 control
    output logic                  sensor_alarm_tx_out,
    output logic                  remote_loop_request_out,
    output logic                  link_loop_active_out,
    output logic                  link_tx_bit_out,
    output logic [PORTS-1:0]      port_ais_out,
    output logic [PORTS-1:0]      port_loop_active_out,
    output logic [PORTS-1:0]      trib_loop_active_out,
    // tester results
    output logic                  pattern_not_detected_out,
    output logic [ERR_CNT_W-1:0]  bit_error_count_out
);
    localparam int             NSYNC = 6 + 3 * PORTS;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_DIV - 1);

    logic [NSYNC-1:0] raw_pins;
    logic [NSYNC-1:0] clean;
    logic             rts_ok;
    logic             frame_loss;
    logic             high_err;
    logic             fe_rts_loss;
    logic             fe_frame_loss;
    logic             fe_sensor;
    logic [PORTS-1:0] carrier_loss;
    logic [PORTS-1:0] ais_rx;
    logic [PORTS-1:0] code_err;

    assign raw_pins = {port_code_error_in, port_ais_rx_in, port_carrier_loss_in, far_end_sensor_alarm_in,
                       far_end_frame_loss_in, far_end_rts_loss_in, link_high_error_in, link_frame_loss_in,
                       link_rts_in};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            pin_sync #(.RESET_VALUE(1'b0)) u_sync (
                .clk_in    (clk_in),
                .reset_in  (reset_in),
                .pin_in    (raw_pins[gi]),
                .level_out (clean[gi])
            );
        end
    endgenerate

    assign rts_ok        = clean[0];
    assign frame_loss    = clean[1];
    assign high_err      = clean[2];
    assign fe_rts_loss   = clean[3];
    assign fe_frame_loss = clean[4];
    assign fe_sensor     = clean[5];
    assign carrier_loss  = clean[6 +: PORTS];
    assign ais_rx        = clean[6 + PORTS +: PORTS];
    assign code_err      = clean[6 + 2 * PORTS +: PORTS];

    // flash cadence divider
    logic [TICK_W-1:0] tick_cnt;
    logic [TICK_W-1:0] next_tick_cnt;
    logic [2:0]        phase;
    logic [2:0]        next_phase;
    logic              flash;
    logic              dflash;

    always_comb begin
        next_tick_cnt = tick_cnt + 1'b1;
        next_phase    = phase;
        if (tick_cnt == TICK_LAST) begin
            next_tick_cnt = '0;
            next_phase    = phase + 1'b1;
        end
    end

    assign flash  = phase[2];
    assign dflash = (phase == 3'h0) || (phase == 3'h2);

    // bit error tester
    tst_state_t        tst_state;
    tst_state_t        next_tst_state;
    logic [PRBS_W-1:0] tx_lfsr;
    logic [PRBS_W-1:0] next_tx_lfsr;
    logic [PRBS_W-1:0] rx_lfsr;
    logic [PRBS_W-1:0] next_rx_lfsr;
    logic [LOSS_CNT_W-1:0] miss_cnt;
    logic [LOSS_CNT_W-1:0] next_miss_cnt;
    logic [ERR_CNT_W-1:0]  next_err_cnt;
    logic              next_pnd;
    logic              tx_test_bit;
    logic              expect_bit;
    logic              tester_err_seen;
    logic              next_tester_err_seen;

    always_comb begin
        next_tx_lfsr         = tx_lfsr;
        next_rx_lfsr         = rx_lfsr;
        next_tst_state       = tst_state;
        next_miss_cnt        = miss_cnt;
        next_err_cnt         = bit_error_count_out;
        next_pnd             = pattern_not_detected_out;
        next_tester_err_seen = 1'b0;
        tx_test_bit          = tester_prbs_select_in ? tx_lfsr[PRBS_TAP_A] : FIXED_PATTERN[tx_lfsr[4:0] % PRBS_W];
        expect_bit           = tester_prbs_select_in ? (rx_lfsr[PRBS_TAP_A] ^ rx_lfsr[PRBS_TAP_B])
                                                     : FIXED_PATTERN[rx_lfsr[4:0] % PRBS_W];
        if (!tester_enable_in) begin
            next_tst_state = tst_hunt;
            next_miss_cnt  = '0;
            next_err_cnt   = '0;
            next_pnd       = 1'b0;
        end else if (link_bit_strobe_in) begin
            if (tester_prbs_select_in) begin
                next_tx_lfsr = {tx_lfsr[PRBS_W-2:0], tx_lfsr[PRBS_TAP_A] ^ tx_lfsr[PRBS_TAP_B]};
            end else begin
                next_tx_lfsr = (tx_lfsr[4:0] == 5'(PRBS_W - 1)) ? '0 : tx_lfsr + 1'b1;
            end
            case (tst_state)
                tst_hunt: begin
                    next_pnd = 1'b1;
                    if (tester_prbs_select_in) begin
                        next_rx_lfsr = {rx_lfsr[PRBS_W-2:0], link_rx_bit_in};
                    end else if (link_rx_bit_in == expect_bit) begin
                        next_rx_lfsr = (rx_lfsr[4:0] == 5'(PRBS_W - 1)) ? '0 : rx_lfsr + 1'b1;
                    end
                    if (link_rx_bit_in == expect_bit) begin
                        next_miss_cnt = miss_cnt + 1'b1;
                        if (miss_cnt == PATTERN_LOSS_LIM) begin
                            next_tst_state = tst_locked;
                            next_miss_cnt  = '0;
                        end
                    end else begin
                        next_miss_cnt = '0;
                    end
                end
                tst_locked: begin
                    next_pnd = 1'b0;
                    if (tester_prbs_select_in) begin
                        next_rx_lfsr = {rx_lfsr[PRBS_W-2:0], expect_bit};
                    end else begin
                        next_rx_lfsr = (rx_lfsr[4:0] == 5'(PRBS_W - 1)) ? '0 : rx_lfsr + 1'b1;
                    end
                    if (link_rx_bit_in != expect_bit) begin
                        next_err_cnt         = bit_error_count_out + 1'b1;
                        next_tester_err_seen = 1'b1;
                        next_miss_cnt        = miss_cnt + 1'b1;
                        if (miss_cnt == PATTERN_LOSS_LIM) begin
                            next_tst_state = tst_hunt;
                        end
                    end else begin
                        next_miss_cnt = '0;
                    end
                end
                default: next_tst_state = tst_hunt;
            endcase
        end
    end

    // indicator, relay and control next values
    logic             next_los_led;
    logic             next_link_error_led_led;
    logic             next_fe_led;
    logic             next_tst_led;
    logic             next_relay;
    logic             next_sensor_tx;
    logic             next_tx_bit;
    logic             own_pattern_back;
    logic             all_ais;
    logic             err_hold;
    logic             next_err_hold;
    logic [PORTS-1:0] next_trib_led;
    logic [PORTS-1:0] next_state_led;
    logic [PORTS-1:0] next_port_ais;
    logic [PORTS-1:0] next_port_loop;
    logic [PORTS-1:0] next_trib_loop;
    logic             next_link_loop;
    logic             next_remote_req;

    always_comb begin
        next_link_loop  = link_loop_enable_in | far_end_loop_request_in;
        next_remote_req = remote_loop_enable_in;
        next_port_loop  = port_loop_enable_in;
        next_trib_loop  = trib_loop_enable_in;
        own_pattern_back = (link_loop_active_out || remote_loop_request_out)
                         && tester_enable_in && (tst_state == tst_locked);
        next_err_hold   = tester_err_seen ? 1'b1 : (phase == 3'h7 ? 1'b0 : err_hold);
        next_los_led    = !rts_ok;
        next_link_error_led_led   = high_err
                        | (tester_enable_in && err_hold && flash)
                        | own_pattern_back;
        next_fe_led     = rts_ok && (fe_rts_loss || fe_frame_loss);
        if (remote_loop_request_out) begin
            next_tst_led = dflash;
        end else if (tester_enable_in || link_loop_active_out) begin
            next_tst_led = flash;
        end else begin
            next_tst_led = 1'b0;
        end
        next_relay = ((!rts_ok) || frame_loss || high_err
                     || |(port_in_use_in & carrier_loss)
                     || fe_sensor) ? RELAY_ALARM : RELAY_NORMAL;
        next_sensor_tx = sensor_alarm_on_open_in ? !sensor_closed_in : sensor_closed_in;
        // ais to every port on link faults, link loop or no tributary data
        all_ais = !rts_ok || frame_loss || high_err
                || link_loop_active_out
                || !rx_trib_data_valid_in || tester_enable_in;
        next_port_ais = {PORTS{all_ais}} | trib_loop_active_out;
        if (link_loop_active_out) begin
            next_tx_bit = link_rx_bit_in;
        end else if (tester_enable_in) begin
            next_tx_bit = tx_test_bit;
        end else begin
            next_tx_bit = tx_mux_bit_in;
        end
        for (int p = 0; p < PORTS; p++) begin
            if (carrier_loss[p] || ais_rx[p]) begin
                next_trib_led[p] = 1'b1;
            end else begin
                next_trib_led[p] = code_err[p] && flash;
            end
            if (!port_in_use_in[p]) begin
                next_state_led[p] = 1'b0;
            end else if (trib_loop_active_out[p]) begin
                next_state_led[p] = dflash;
            end else if (port_loop_active_out[p]) begin
                next_state_led[p] = flash;
            end else begin
                next_state_led[p] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            tick_cnt                 <= '0;
            phase                    <= '0;
            tst_state                <= tst_hunt;
            tx_lfsr                  <= PRBS_SEED;
            rx_lfsr                  <= PRBS_SEED;
            miss_cnt                 <= '0;
            bit_error_count_out      <= '0;
            pattern_not_detected_out <= 1'b0;
            tester_err_seen          <= 1'b0;
            err_hold                 <= 1'b0;
            link_signal_loss_led_out <= 1'b0;
            link_error_led_out       <= 1'b0;
            far_end_error_led_out    <= 1'b0;
            test_mode_led_out        <= 1'b0;
            power_led_out            <= 1'b0;
            tributary_loss_led_out   <= '0;
            port_state_led_out       <= '0;
            alarm_relay_out          <= RELAY_ALARM;
            sensor_alarm_tx_out      <= 1'b0;
            remote_loop_request_out  <= 1'b0;
            link_loop_active_out     <= 1'b0;
            port_loop_active_out     <= '0;
            trib_loop_active_out     <= '0;
            link_tx_bit_out          <= AIS_BIT;
            port_ais_out             <= {PORTS{AIS_BIT}};
        end else begin
            tick_cnt                 <= next_tick_cnt;
            phase                    <= next_phase;
            tst_state                <= next_tst_state;
            tx_lfsr                  <= next_tx_lfsr;
            rx_lfsr                  <= next_rx_lfsr;
            miss_cnt                 <= next_miss_cnt;
            bit_error_count_out      <= next_err_cnt;
            pattern_not_detected_out <= next_pnd;
            tester_err_seen          <= next_tester_err_seen;
            err_hold                 <= next_err_hold;
            link_signal_loss_led_out <= next_los_led;
            link_error_led_out       <= next_link_error_led_led;
            far_end_error_led_out    <= next_fe_led;
            test_mode_led_out        <= next_tst_led;
            power_led_out            <= 1'b1;
            tributary_loss_led_out   <= next_trib_led;
            port_state_led_out       <= next_state_led;
            alarm_relay_out          <= next_relay;
            sensor_alarm_tx_out      <= next_sensor_tx;
            remote_loop_request_out  <= next_remote_req;
            link_loop_active_out     <= next_link_loop;
            port_loop_active_out     <= next_port_loop;
            trib_loop_active_out     <= next_trib_loop;
            link_tx_bit_out          <= next_tx_bit;
            port_ais_out             <= next_port_ais;
        end
    end
endmodule

// ### verilog/pin_sync.sv
// three-stage synchroniser for one asynchronous pin, change accepted when stages two and three agree
// assumes clk_in system clock, synchronous active-high reset
`timescale 1ns/1ps
module pin_sync
    import supervisor_pkg::*;
#(
    parameter logic RESET_VALUE = 1'b0
) (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic reset_in,
    // pin in, clean level out
    input  wire logic pin_in,
    output logic      level_out
);
    logic [SYNC_STAGES-1:0] stages;
    logic [SYNC_STAGES-1:0] next_stages;
    logic                   next_level;

    always_comb begin
        next_stages = {stages[SYNC_STAGES-2:0], pin_in};
        next_level  = level_out;
        if (stages[1] == stages[2]) begin
            next_level = stages[2];
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            stages    <= {SYNC_STAGES{RESET_VALUE}};
            level_out <= RESET_VALUE;
        end else begin
            stages    <= next_stages;
            level_out <= next_level;
        end
    end
endmodule

// ### verilog/supervisor_pkg.sv
// constants for the e1 multiplexer status, alarm, loop and tester supervisor
// assumes a 100 MHz system clock and single synchronous reset
package supervisor_pkg;
    localparam int          CLK_MHZ          = 100;
    localparam int          SLOW_TICK_HZ     = 8;
    localparam int          TICK_CYCLES      = CLK_MHZ * 1000000 / SLOW_TICK_HZ;
    localparam int          TICK_W           = 24;
    localparam int          PRBS_W           = 23;
    localparam int          PRBS_TAP_A       = 22;
    localparam int          PRBS_TAP_B       = 17;
    localparam logic [22:0] PRBS_SEED        = 23'h7fffff;
    localparam int          ERR_CNT_W        = 32;
    localparam int          LOSS_CNT_W       = 16;
    localparam logic [15:0] PATTERN_LOSS_LIM = 16'h0400;
    localparam logic        AIS_BIT          = 1'b1;
    localparam logic        RELAY_ALARM      = 1'b0;
    localparam logic        RELAY_NORMAL     = 1'b1;
    localparam int          SYNC_STAGES      = 3;

    typedef enum logic [1:0] {
        led_off    = 2'b00,
        led_on     = 2'b01,
        led_flash  = 2'b10,
        led_dflash = 2'b11
    } led_mode_t;

    typedef enum logic [0:0] {
        tst_hunt   = 1'b0,
        tst_locked = 1'b1
    } tst_state_t;
endpackage
